/* File: design/aoi_pkg.sv */
// constants and types shared by the converter output interface
package aoi_pkg;
    // system clock and the internal conversion oscillator
    localparam int unsigned CLK_HZ     = 200_000_000;
    localparam int unsigned INT_OSC_HZ = 2_000_000;
    localparam int unsigned INT_DIV    = CLK_HZ / INT_OSC_HZ;
    localparam int unsigned DIV_W      = 7;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);

    // result word and conversion length in conversion clock ticks
    localparam int unsigned RESULT_W   = 14;
    localparam int unsigned CNT_W      = 5;
    localparam logic [CNT_W-1:0] CONV_TICKS = 5'h10;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h0E;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

    // format select codes (three-level pin after level detection)
    localparam logic [1:0] FMT_PARALLEL = 2'h0;
    localparam logic [1:0] FMT_GATED    = 2'h1;
    localparam logic [1:0] FMT_CONT     = 2'h2;

    // pin field positions and fill values
    localparam int unsigned SYNC_W      = 8;
    localparam int unsigned S_START     = 0;
    localparam int unsigned S_CS        = 1;
    localparam int unsigned S_RD        = 2;
    localparam int unsigned S_CLKPIN    = 3;
    localparam int unsigned S_INTOSC    = 4;
    localparam int unsigned S_FMT       = 5;
    localparam int unsigned S_HBS       = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'h06;
    localparam logic [1:0] BYTE_PAD     = 2'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } aoi_conv_state_type;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_WAIT  = 2'b01,
        SER_SHIFT = 2'b10
    } aoi_ser_state_type;
endpackage

/* File: design/aoi_conv_if.sv */
// signals between the top, the conversion engine and the serialiser
`timescale 1ns/10ps
interface aoi_conv_if;
    import aoi_pkg::*;
    logic                tick;
    logic                done;
    logic [RESULT_W-1:0] result;
    logic                frame;
    logic                sclk;
    logic                sbit;
    modport conv (input tick, output done, output result);
    modport ser  (input tick, input done, input result, output frame, output sclk, output sbit);
    modport top  (output tick, input done, input result, input frame, input sclk, input sbit);
endinterface

/* File: design/aoi_conv_core.sv */
// conversion engine: hold, count conversion ticks, publish result
`timescale 1ns/10ps
module aoi_conv_core
    import aoi_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                start,
    input  wire logic [RESULT_W-1:0] sample_data,
    output logic                     busy,
    aoi_conv_if.conv                 cif
);
    aoi_conv_state_type  state_reg,  state_next;
    logic [CNT_W-1:0]    cnt_reg,    cnt_next;
    logic [RESULT_W-1:0] held_reg,   held_next;
    logic [RESULT_W-1:0] result_reg, result_next;
    logic                done_reg,   done_next;

    // a start while converting is ignored: the held sample must not move
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        held_next   = held_reg;
        result_next = result_reg;
        done_next   = 1'b0;
        case (state_reg)
            CONV_IDLE: begin
                if (start) begin
                    held_next  = sample_data;
                    cnt_next   = CNT_ZERO;
                    state_next = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (cif.tick) begin
                    cnt_next = cnt_reg + CNT_ONE;
                    if (cnt_reg == CONV_TICKS - CNT_ONE) begin
                        result_next = held_reg;
                        done_next   = 1'b1;
                        state_next  = CONV_IDLE;
                    end
                end
            end
            default: state_next = CONV_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg  <= CONV_IDLE;
            cnt_reg    <= CNT_ZERO;
            held_reg   <= RESULT_RST;
            result_reg <= RESULT_RST;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            held_reg   <= held_next;
            result_reg <= result_next;
            done_reg   <= done_next;
        end
    end

    assign busy       = (state_reg == CONV_RUN);
    assign cif.done   = done_reg;
    assign cif.result = result_reg;
endmodule

/* File: design/aoi_serial_tx.sv */
// serialiser: free shift clock and one framed word per result that arrives while idle
`timescale 1ns/10ps
module aoi_serial_tx
    import aoi_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    aoi_conv_if.ser   sif
);
    aoi_ser_state_type   state_reg, state_next;
    logic                sclk_reg,  sclk_next;
    logic                sbit_reg,  sbit_next;
    logic [RESULT_W-1:0] shift_reg, shift_next;
    logic [CNT_W-1:0]    cnt_reg,   cnt_next;

    // clock toggles on every tick; the top decides whether it reaches the pin
    always_comb begin
        state_next = state_reg;
        sclk_next  = sclk_reg;
        sbit_next  = sbit_reg;
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        if (sif.tick) begin
            sclk_next = ~sclk_reg;
        end
        case (state_reg)
            SER_IDLE: begin
                if (sif.done) begin
                    shift_next = sif.result;
                    state_next = SER_WAIT;
                end
            end
            SER_WAIT: begin
                // start on a rising edge so the first bit settles before a fall
                if (sif.tick && !sclk_reg) begin
                    sbit_next  = shift_reg[RESULT_W-1];
                    shift_next = {shift_reg[RESULT_W-2:0], 1'b0};
                    cnt_next   = CNT_ZERO;
                    state_next = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (sif.tick && sclk_reg) begin
                    cnt_next = cnt_reg + CNT_ONE; // bit sampled at this fall
                end else if (sif.tick && !sclk_reg) begin
                    if (cnt_reg == FRAME_BITS) begin
                        state_next = SER_IDLE;
                    end else begin
                        sbit_next  = shift_reg[RESULT_W-1];
                        shift_next = {shift_reg[RESULT_W-2:0], 1'b0};
                    end
                end
            end
            default: state_next = SER_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SER_IDLE;
            sclk_reg  <= 1'b0;
            sbit_reg  <= 1'b0;
            shift_reg <= RESULT_RST;
            cnt_reg   <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            sclk_reg  <= sclk_next;
            sbit_reg  <= sbit_next;
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign sif.frame = (state_reg == SER_SHIFT);
    assign sif.sclk  = sclk_reg;
    assign sif.sbit  = sbit_reg;
endmodule

/* File: design/aoi_top.sv */
// output interface of a 14-bit sampling converter: start, status, result pins
`timescale 1ns/10ps
module aoi_top
    import aoi_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                convert_start,
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                conv_clk_pin,
    input  wire logic                conv_clk_internal,
    input  wire logic [1:0]          format_sel,
    input  wire logic [RESULT_W-1:0] sample_data,
    input  wire logic                msb_or_byte_select_in,
    output logic                     busy_n,
    output logic                     msb_or_byte_select_out,
    output logic                     msb_or_byte_select_oe_n,
    output logic                     db12_or_frame_out,
    output logic                     db12_or_frame_oe_n,
    output logic                     db11_or_sclk_out,
    output logic                     db11_or_sclk_oe_n,
    output logic                     db10_or_serial_out_out,
    output logic                     db10_or_serial_out_oe_n,
    output logic [9:0]               data_low_out,
    output logic [1:0]               data_top_oe_n,
    output logic [7:0]               data_byte_oe_n
);
    aoi_conv_if cif ();

    // two-stage synchronisers for every pin input
    logic [SYNC_W-1:0] sync1_reg, sync1_next;
    logic [SYNC_W-1:0] sync2_reg, sync2_next;
    logic [SYNC_W-1:0] prev_reg,  prev_next;

    // conversion clock enable
    logic [DIV_W-1:0]  div_reg,   div_next;
    logic              tick_reg,  tick_next;

    // start detection
    logic              start_reg, start_next;
    logic              busy;

    // pin output flops
    logic              busy_n_reg,   busy_n_next;
    logic              p13_reg,      p13_next;
    logic              p13_oe_n_reg, p13_oe_n_next;
    logic              p12_reg,      p12_next;
    logic              p12_oe_n_reg, p12_oe_n_next;
    logic              p11_reg,      p11_next;
    logic              p11_oe_n_reg, p11_oe_n_next;
    logic              p10_reg,      p10_next;
    logic              p10_oe_n_reg, p10_oe_n_next;
    logic [9:0]        low_reg,      low_next;
    logic [1:0]        top_oe_n_reg, top_oe_n_next;
    logic [7:0]        byte_oe_n_reg, byte_oe_n_next;

    // synchronised views, all taken from the second stage
    logic              conv_s;
    logic              cs_s;
    logic              rd_s;
    logic              clkpin_s;
    logic              intosc_s;
    logic [1:0]        fmt_s;
    logic              hbs_s;
    logic              parallel;
    logic              gated;
    logic              read_en;

    assign conv_s   = sync2_reg[S_START];
    assign cs_s     = sync2_reg[S_CS];
    assign rd_s     = sync2_reg[S_RD];
    assign clkpin_s = sync2_reg[S_CLKPIN];
    assign intosc_s = sync2_reg[S_INTOSC];
    assign fmt_s    = sync2_reg[S_FMT +: 2];
    assign hbs_s    = sync2_reg[S_HBS];

    // code 3 is not a legal pin level; treat it as gated so the clock pin is driven only inside a frame
    assign parallel = (fmt_s == FMT_PARALLEL);
    assign gated    = (fmt_s != FMT_CONT);
    assign read_en  = !cs_s && !rd_s;

    // synchroniser chain: the first stage feeds only the second
    always_comb begin
        sync1_next = {msb_or_byte_select_in, format_sel, conv_clk_internal,
                      conv_clk_pin, rd_n, cs_n, convert_start};
        sync2_next = sync1_reg;
        prev_next  = sync2_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
            prev_reg  <= SYNC_RST;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg  <= prev_next;
        end
    end

    // conversion clock: divider for the internal oscillator, edge of the pin
    // otherwise; the external rate must stay well under a quarter of clk
    always_comb begin
        div_next  = div_reg;
        tick_next = 1'b0;
        if (intosc_s) begin
            if (div_reg == DIV_LAST) begin
                div_next  = '0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + DIV_W'(1);
            end
        end else begin
            div_next  = '0;
            tick_next = clkpin_s && !prev_reg[S_CLKPIN];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign cif.tick = tick_reg;

    // start: rising convert_start, or select falling while convert_start low
    always_comb begin
        start_next = 1'b0;
        if (conv_s && !prev_reg[S_START]) begin
            start_next = 1'b1;
        end else if (!conv_s && !prev_reg[S_START] && !cs_s && prev_reg[S_CS]) begin
            start_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start_next;
        end
    end

    aoi_conv_core u_core (
        .clk         (clk),
        .rst         (rst),
        .start       (start_reg),
        .sample_data (sample_data),
        .busy        (busy),
        .cif         (cif.conv)
    );

    aoi_serial_tx u_ser (
        .clk (clk),
        .rst (rst),
        .sif (cif.ser)
    );

    // pin multiplexing; every pin value and enable is registered
    always_comb begin
        busy_n_next    = !busy;
        p13_next       = 1'b0;
        p13_oe_n_next  = 1'b1;
        p12_next       = 1'b0;
        p12_oe_n_next  = 1'b1;
        p11_next       = 1'b0;
        p11_oe_n_next  = 1'b1;
        p10_next       = 1'b0;
        p10_oe_n_next  = 1'b1;
        low_next       = 10'h000;
        top_oe_n_next  = 2'h3;
        byte_oe_n_next = 8'hFF;
        if (parallel) begin
            p13_next       = cif.result[13];
            p12_next       = cif.result[12];
            p11_next       = cif.result[11];
            p10_next       = cif.result[10];
            low_next       = cif.result[9:0];
            p13_oe_n_next  = !read_en;
            p12_oe_n_next  = !read_en;
            p11_oe_n_next  = !read_en;
            p10_oe_n_next  = !read_en;
            top_oe_n_next  = {2{!read_en}};
            byte_oe_n_next = {8{!read_en}};
        end else begin
            // the shared pin is an input here, so it is never driven
            if (hbs_s) begin
                low_next[7:0] = {BYTE_PAD, cif.result[13:8]};
            end else begin
                low_next[7:0] = cif.result[7:0];
            end
            byte_oe_n_next = {8{!read_en}};
            p12_next       = 1'b0;
            p12_oe_n_next  = !cif.frame;
            p11_next       = cif.sclk;
            p11_oe_n_next  = gated ? !cif.frame : 1'b0;
            p10_next       = cif.sbit;
            p10_oe_n_next  = !cif.frame;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_n_reg    <= 1'b1;
            p13_reg       <= 1'b0;
            p13_oe_n_reg  <= 1'b1;
            p12_reg       <= 1'b0;
            p12_oe_n_reg  <= 1'b1;
            p11_reg       <= 1'b0;
            p11_oe_n_reg  <= 1'b1;
            p10_reg       <= 1'b0;
            p10_oe_n_reg  <= 1'b1;
            low_reg       <= 10'h000;
            top_oe_n_reg  <= 2'h3;
            byte_oe_n_reg <= 8'hFF;
        end else begin
            busy_n_reg    <= busy_n_next;
            p13_reg       <= p13_next;
            p13_oe_n_reg  <= p13_oe_n_next;
            p12_reg       <= p12_next;
            p12_oe_n_reg  <= p12_oe_n_next;
            p11_reg       <= p11_next;
            p11_oe_n_reg  <= p11_oe_n_next;
            p10_reg       <= p10_next;
            p10_oe_n_reg  <= p10_oe_n_next;
            low_reg       <= low_next;
            top_oe_n_reg  <= top_oe_n_next;
            byte_oe_n_reg <= byte_oe_n_next;
        end
    end

    // ports straight from flops
    assign busy_n                  = busy_n_reg;
    assign msb_or_byte_select_out  = p13_reg;
    assign msb_or_byte_select_oe_n = p13_oe_n_reg;
    assign db12_or_frame_out       = p12_reg;
    assign db12_or_frame_oe_n      = p12_oe_n_reg;
    assign db11_or_sclk_out        = p11_reg;
    assign db11_or_sclk_oe_n       = p11_oe_n_reg;
    assign db10_or_serial_out_out  = p10_reg;
    assign db10_or_serial_out_oe_n = p10_oe_n_reg;
    assign data_low_out            = low_reg;
    assign data_top_oe_n           = top_oe_n_reg;
    assign data_byte_oe_n          = byte_oe_n_reg;
endmodule

/* File: tb/aoi_host_model.sv */
// host side model: board pull-ups on the serial pins and a frame receiver
`timescale 1ns/10ps
module aoi_host_model
    import aoi_pkg::*;
(
    input  wire logic           frame_out,
    input  wire logic           frame_oe_n,
    input  wire logic           sclk_out,
    input  wire logic           sclk_oe_n,
    input  wire logic           sbit_out,
    input  wire logic           sbit_oe_n,
    output logic [RESULT_W-1:0] rx_word,
    output logic [CNT_W-1:0]    rx_bits,
    output int                  rx_count
);
    logic                frame_w;
    logic                sclk_w;
    logic                sbit_w;
    logic [RESULT_W-1:0] shift_reg;
    logic [CNT_W-1:0]    bits_reg;

    // released pins float high through the pull-ups, never hold a stale level
    assign frame_w = frame_oe_n ? 1'b1 : frame_out;
    assign sclk_w  = sclk_oe_n ? 1'b1 : sclk_out;
    assign sbit_w  = sbit_oe_n ? 1'b1 : sbit_out;

    initial begin
        rx_count  = 0;
        bits_reg  = CNT_ZERO;
        shift_reg = RESULT_RST;
    end

    // take each bit on a falling shift clock inside the frame, msb first;
    // the short settle rejects the zero glitch a gated clock can show while
    // its value and enable change in one step
    always @(negedge sclk_w) begin
        #1;
        if (!sclk_w && !frame_w) begin
            shift_reg <= {shift_reg[RESULT_W-2:0], sbit_w};
            bits_reg  <= bits_reg + CNT_ONE;
        end
    end

    // end of frame hands the word over and rearms the bit count
    always @(posedge frame_w) begin
        rx_word  <= shift_reg;
        rx_bits  <= bits_reg;
        rx_count <= rx_count + 1;
        bits_reg <= CNT_ZERO;
    end
endmodule

/* File: tb/aoi_top_properties.sv */
// concurrent checks on the pins of the converter output interface
`timescale 1ns/10ps
module aoi_top_properties
    import aoi_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       convert_start,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic [1:0] format_sel,
    input wire logic       msb_or_byte_select_in,
    input wire logic       busy_n,
    input wire logic       msb_or_byte_select_oe_n,
    input wire logic       db12_or_frame_out,
    input wire logic       db12_or_frame_oe_n,
    input wire logic       db11_or_sclk_out,
    input wire logic       db11_or_sclk_oe_n,
    input wire logic       db10_or_serial_out_out,
    input wire logic [9:0] data_low_out,
    input wire logic [1:0] data_top_oe_n,
    input wire logic [7:0] data_byte_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // bus requests held long enough to pass the input synchronisers
    sequence s_par_read;
        (!cs_n && !rd_n && format_sel == FMT_PARALLEL) [*4];
    endsequence
    sequence s_bus_off;
        (cs_n || rd_n) [*4];
    endsequence
    sequence s_byte_hi;
        (!cs_n && !rd_n && format_sel != FMT_PARALLEL && msb_or_byte_select_in) [*4];
    endsequence
    sequence s_pin_start;
        busy_n && cs_n && rd_n && $rose(convert_start);
    endsequence
    sequence s_sel_start;
        busy_n && !convert_start && $fell(cs_n);
    endsequence

    property p_par_drive;
        s_par_read |=> data_byte_oe_n == 8'h00 && data_top_oe_n == 2'h0
            && !msb_or_byte_select_oe_n && !db12_or_frame_oe_n && !db11_or_sclk_oe_n;
    endproperty
    property p_bus_off;
        s_bus_off |=> data_byte_oe_n == 8'hFF && data_top_oe_n == 2'h3;
    endproperty
    property p_byte_hi;
        s_byte_hi |=> data_low_out[7:6] == BYTE_PAD && data_top_oe_n == 2'h3
            && data_byte_oe_n == 8'h00 && msb_or_byte_select_oe_n;
    endproperty
    property p_start_busy;
        s_pin_start |-> ##[5:6] !busy_n;
    endproperty
    property p_select_busy;
        s_sel_start |-> ##[5:6] !busy_n;
    endproperty
    property p_frame_low;
        format_sel != FMT_PARALLEL && !db12_or_frame_oe_n |-> !db12_or_frame_out;
    endproperty
    // three cycles of slack on either side of the frame edges
    property p_gated_sclk;
        (format_sel == FMT_GATED && db12_or_frame_oe_n) [*7] |-> $past(db11_or_sclk_oe_n, 3);
    endproperty
    property p_cont_sclk;
        (format_sel == FMT_CONT) [*8] |-> !db11_or_sclk_oe_n;
    endproperty
    property p_serial_out_stable;
        format_sel != FMT_PARALLEL && !db12_or_frame_oe_n && $fell(db11_or_sclk_out)
            |-> $stable(db10_or_serial_out_out);
    endproperty

    a_par_drive: assert property (p_par_drive) else $error("parallel read not driven");
    a_bus_off: assert property (p_bus_off) else $error("data pins driven off read");
    a_byte_hi: assert property (p_byte_hi) else $error("high byte mapping wrong");
    a_start_busy: assert property (p_start_busy) else $error("start pin ignored");
    a_select_busy: assert property (p_select_busy) else $error("select start ignored");
    a_frame_low: assert property (p_frame_low) else $error("frame driven high");
    a_gated_sclk: assert property (p_gated_sclk) else $error("gated clock driven");
    a_cont_sclk: assert property (p_cont_sclk) else $error("continuous clock off");
    a_serial_out_stable: assert property (p_serial_out_stable) else $error("data moved at fall");
endmodule

bind aoi_top aoi_top_properties u_props (
    .clk, .rst, .convert_start, .cs_n, .rd_n, .format_sel, .msb_or_byte_select_in,
    .busy_n, .msb_or_byte_select_oe_n, .db12_or_frame_out, .db12_or_frame_oe_n,
    .db11_or_sclk_out, .db11_or_sclk_oe_n, .db10_or_serial_out_out,
    .data_low_out, .data_top_oe_n, .data_byte_oe_n
);

/* File: tb/aoi_top_tb.sv */
// self-checking bench for the converter output interface
`timescale 1ns/10ps
module aoi_top_tb;
    import aoi_pkg::*;
    logic                clk      = 1'b0;
    logic                rst      = 1'b1;
    logic                cstart   = 1'b0;
    logic                cs_n     = 1'b1;
    logic                rd_n     = 1'b1;
    logic                cclk     = 1'b0;
    logic                int_osc  = 1'b0;
    logic [1:0]          fmt      = FMT_PARALLEL;
    logic [RESULT_W-1:0] sample   = 14'h0000;
    logic                hbs      = 1'b0;
    logic                ext_run  = 1'b1;
    logic [1:0]          div      = 2'h0;
    int                  n_errors = 0;
    int                  compares = 0;
    int                  cycles   = 0;
    wire logic           busy_n;
    wire logic [13:0]    pins;
    wire logic [13:0]    oes;
    wire logic           msb_wire;
    logic [RESULT_W-1:0] rx_word;
    logic [CNT_W-1:0]    rx_bits;
    int                  rx_count;

    // host drives the shared select pin only while the device releases it
    assign msb_wire = oes[13] ? hbs : pins[13];

    aoi_top uut (
        .clk(clk), .rst(rst), .convert_start(cstart), .cs_n(cs_n), .rd_n(rd_n),
        .conv_clk_pin(cclk), .conv_clk_internal(int_osc), .format_sel(fmt),
        .sample_data(sample), .msb_or_byte_select_in(msb_wire), .busy_n(busy_n),
        .msb_or_byte_select_out(pins[13]), .msb_or_byte_select_oe_n(oes[13]),
        .db12_or_frame_out(pins[12]), .db12_or_frame_oe_n(oes[12]),
        .db11_or_sclk_out(pins[11]), .db11_or_sclk_oe_n(oes[11]),
        .db10_or_serial_out_out(pins[10]), .db10_or_serial_out_oe_n(oes[10]),
        .data_low_out(pins[9:0]), .data_top_oe_n(oes[9:8]), .data_byte_oe_n(oes[7:0])
    );

    aoi_host_model host (
        .frame_out(pins[12]), .frame_oe_n(oes[12]), .sclk_out(pins[11]),
        .sclk_oe_n(oes[11]), .sbit_out(pins[10]), .sbit_oe_n(oes[10]),
        .rx_word(rx_word), .rx_bits(rx_bits), .rx_count(rx_count)
    );

    // system clock, and an external conversion clock of eight system cycles
    always #2.5 clk = ~clk;
    always @(negedge clk) begin
        div <= div + 2'h1;
        if (ext_run && div == 2'h3) cclk <= ~cclk;
    end

    // hang guard: the whole run needs about a quarter of this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wait_busy(input logic lvl, input int lim, output int n);
        n = 0;
        while (busy_n !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (busy_n !== lvl) begin
            n_errors++;
            $display("[FAIL] %0t ns busy wait timed out", $time);
        end
    endtask

    // start pulse with select and read parked high, then time the busy phase
    task automatic convert(input int lo, input int hi);
        int n;
        @(negedge clk);
        cstart = 1'b1;
        wait_busy(1'b0, 10, n);
        chk(14'(n), 14'h0005, "start to busy");
        cstart = 1'b0;
        wait_busy(1'b1, 2000, n);
        chk(14'(n >= lo && n <= hi), 14'h0001, "busy length");
    endtask

    // one read cycle; the select edge also starts a conversion, so wait it out
    task automatic read_bus(output logic [13:0] d, output logic [13:0] e);
        int n;
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (4) @(negedge clk);
        d = pins;
        e = oes;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({4'h0, oes[9:0]}, 14'h03FF, "enables after read");
        wait_busy(1'b1, 400, n);
    endtask

    task automatic t_parallel();
        logic [13:0] d;
        logic [13:0] e;
        fmt = FMT_PARALLEL;
        sample = 14'h2A5C;
        convert(118, 140);
        read_bus(d, e);
        chk(d, 14'h2A5C, "parallel word");
        chk(e, 14'h0000, "parallel enables");
    endtask

    // select falling with the start pin low begins a conversion, read stays off
    task automatic t_select();
        int n;
        @(negedge clk);
        cs_n = 1'b0;
        wait_busy(1'b0, 10, n);
        chk(14'(n), 14'h0005, "select to busy");
        chk(oes, 14'h3FFF, "enables with read high");
        cs_n = 1'b1;
        wait_busy(1'b1, 400, n);
    endtask

    task automatic t_serial(input logic [1:0] f, input logic [13:0] s);
        logic [13:0] d;
        logic [13:0] e;
        int          cnt;
        int          n;
        fmt = f;
        sample = s;
        repeat (300) @(negedge clk);
        cnt = rx_count;
        convert(118, 140);
        n = 0;
        while (rx_count == cnt && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk(rx_word, s, "serial word");
        chk({9'h000, rx_bits}, 14'h000E, "serial bit count");
        repeat (8) @(negedge clk);
        chk({12'h000, oes[12:11]}, {12'h000, 1'b1, f == FMT_GATED}, "idle pins");
        hbs = 1'b0;
        read_bus(d, e);
        chk({6'h00, d[7:0]}, {6'h00, s[7:0]}, "low byte");
        chk(e, {2'h3, f == FMT_GATED, 1'b1, 2'h3, 8'h00}, "byte enables");
        hbs = 1'b1;
        read_bus(d, e);
        chk({6'h00, d[7:0]}, {8'h00, s[13:8]}, "high byte");
        repeat (700) @(negedge clk);
    endtask

    // internal oscillator strap with the clock pin held low
    task automatic t_internal();
        fmt = FMT_PARALLEL;
        int_osc = 1'b1;
        ext_run = 1'b0;
        @(negedge clk);
        cclk = 1'b0;
        repeat (8) @(negedge clk);
        convert(1550, 1720);
        int_osc = 1'b0;
        ext_run = 1'b1;
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_parallel();
        t_select();
        t_serial(FMT_GATED, 14'h1B3E);
        t_serial(FMT_CONT, 14'h2C41);
        t_internal();
        end_sim();
    end
endmodule
